/* rtl/mlfp_defs.svh */
// Register offsets, field positions, reset values and timing constants.
`ifndef MLFP_DEFS_SVH
`define MLFP_DEFS_SVH
`define MLFP_OFF_CFG1   8'h00
`define MLFP_OFF_LIMIT  8'h04
`define MLFP_OFF_STAT   8'h08
`define MLFP_OFF_MASK   8'h0C
`define MLFP_OFF_STATE  8'h10
`define MLFP_OFF_CTRL   8'h14
`define MLFP_WAIT_HI    10
`define MLFP_WAIT_LO    7
`define MLFP_MODE_HI    6
`define MLFP_MODE_LO    3
`define MLFP_PTO_BIT    2
`define MLFP_PFQ_BIT    1
`define MLFP_SAT_BIT    0
`define MLFP_CFG1_RESET 11'h000
`define MLFP_LIMIT_RESET 3'h0
`define MLFP_ST_LOCK    0
`define MLFP_ST_RETRY   1
`define MLFP_ST_LATCH   2
`define MLFP_ST_PTO     3
`define MLFP_ST_PFQ     4
`define MLFP_ST_SAT     5
`define MLFP_CLK_PERIOD_NS 5
`define MLFP_NS_PER_MS  1000000
`define MLFP_UNIT_MS    100
`define MLFP_WAIT0_MS   300
`define MLFP_WAIT1_MS   500
`define MLFP_WAIT2_MS   1000
`define MLFP_STEP_MS    1000
`endif

/* rtl/mlfp_pkg.sv */
// Types of the motor lock fault policy block.
package mlfp_pkg;
    typedef enum logic [1:0] {
        MLFP_IDLE   = 2'b00,
        MLFP_WAIT   = 2'b01,
        MLFP_LATCH  = 2'b10,
        MLFP_REPORT = 2'b11
    } mlfp_state_e;
    typedef enum logic [2:0] {
        MLFP_ACT_LATCH_TRI = 3'b000,
        MLFP_ACT_LATCH_BRK = 3'b001,
        MLFP_ACT_RETRY_TRI = 3'b010,
        MLFP_ACT_RETRY_BRK = 3'b011,
        MLFP_ACT_REPORT    = 3'b100,
        MLFP_ACT_OFF       = 3'b101
    } mlfp_act_e;
    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic [10:0] cfg;
        logic [2:0]  limit;
        logic [5:0]  status;
        logic [5:0]  mask;
        mlfp_state_e fsm;
        logic        brake;
        logic [2:0]  retry_cnt;
        logic [31:0] presc;
        logic [7:0]  units;
        logic        fault_n;
        logic        gate_off;
        logic [2:0]  low_on;
        logic        pto_f;
        logic        pfq_f;
        logic        sat_f;
        logic        irq;
    } mlfp_state_s;
endpackage

/* rtl/mlfp_top.sv */
// Motor lock fault policy: config register bank, lock response and retry engine.
`timescale 1ns/1ps
`include "mlfp_defs.svh"
module mlfp_top #(
    parameter int UNIT_CYCLES =
        (`MLFP_UNIT_MS * `MLFP_NS_PER_MS) / `MLFP_CLK_PERIOD_NS
) (
    input  wire logic        pclk,             // Clock, 200 MHz.
    input  wire logic        presetn,          // Asynchronous reset, active low.
    input  wire logic [7:0]  paddr,            // APB byte address.
    input  wire logic        psel,             // APB select.
    input  wire logic        penable,          // APB enable.
    input  wire logic        pwrite,           // APB direction, high for write.
    input  wire logic [31:0] pwdata,           // APB write data.
    output logic      [31:0] prdata,           // APB read data.
    output logic             pready,           // APB ready.
    output logic             pslverr,          // APB error on unmapped address.
    input  wire logic        lock_detect,      // Motor lock detected, level.
    input  wire logic        restart_ok,       // Motor restarted successfully.
    input  wire logic        probe_timeout_in, // Rotor probe timeout seen.
    input  wire logic        probe_freq_in,    // Rotor probe frequency error seen.
    input  wire logic        loop_sat_in,      // Current or speed loop saturated.
    output logic             fault_output_n,   // Fault pin, active low.
    output logic             gate_tristate,    // All gate drivers off.
    output logic      [2:0]  low_side_on,      // Low-side switches on for braking.
    output logic             probe_timeout_fault, // Gated probe timeout fault.
    output logic             probe_freq_fault,    // Gated probe frequency fault.
    output logic             loop_sat_flag,    // Gated loop saturation flag.
    output logic             irq               // Interrupt, active high level.
);
    mlfp_pkg::mlfp_state_s st_reg;
    mlfp_pkg::mlfp_state_s st_next;
    mlfp_pkg::mlfp_act_e   act;
    logic                  acc;
    logic                  wr;
    logic [7:0]            target;
    logic [5:0]            ev;
    logic [5:0]            clr;
    logic                  unit_tick;

    localparam logic [31:0] UNIT_LAST = 32'(UNIT_CYCLES - 1);

    // Retry wait in units of 100 ms for a given code.
    function automatic logic [7:0] wait_units(input logic [3:0] code);
        logic [7:0] u;
        u = 8'h00;
        if (code == 4'h0) begin
            u = 8'(`MLFP_WAIT0_MS / `MLFP_UNIT_MS);
        end else if (code == 4'h1) begin
            u = 8'(`MLFP_WAIT1_MS / `MLFP_UNIT_MS);
        end else if (code == 4'h2) begin
            u = 8'(`MLFP_WAIT2_MS / `MLFP_UNIT_MS);
        end else if (code == 4'hF) begin
            u = 8'(((`MLFP_STEP_MS * 13) / `MLFP_UNIT_MS));
        end else begin
            u = 8'(((`MLFP_STEP_MS * (int'(code) - 1)) / `MLFP_UNIT_MS));
        end
        return u;
    endfunction

    // Lock response action for a given mode code.
    function automatic mlfp_pkg::mlfp_act_e decode(input logic [3:0] m);
        mlfp_pkg::mlfp_act_e a;
        a = mlfp_pkg::MLFP_ACT_OFF;
        case (m)
            4'h0, 4'h1: a = mlfp_pkg::MLFP_ACT_LATCH_TRI;
            4'h2, 4'h3: a = mlfp_pkg::MLFP_ACT_LATCH_BRK;
            4'h4, 4'h5: a = mlfp_pkg::MLFP_ACT_RETRY_TRI;
            4'h6, 4'h7: a = mlfp_pkg::MLFP_ACT_RETRY_BRK;
            4'h8:       a = mlfp_pkg::MLFP_ACT_REPORT;
            default:    a = mlfp_pkg::MLFP_ACT_OFF;
        endcase
        return a;
    endfunction

    always_comb begin
        st_next = st_reg;
        act     = decode(st_reg.cfg[`MLFP_MODE_HI:`MLFP_MODE_LO]);
        target  = wait_units(st_reg.cfg[`MLFP_WAIT_HI:`MLFP_WAIT_LO]);
        acc     = psel && penable && st_reg.pready;
        wr      = acc && pwrite;
        ev      = 6'h00;
        clr     = 6'h00;
        unit_tick = 1'b0;
        // Zero wait states: ready rises in the first access cycle.
        st_next.pready  = psel && !penable;
        st_next.pslverr = 1'b0;
        if (psel && !penable) begin
            st_next.prdata = 32'h0000_0000;
            if (paddr == `MLFP_OFF_CFG1) begin
                st_next.prdata = {21'h00_0000, st_reg.cfg};
            end else if (paddr == `MLFP_OFF_LIMIT) begin
                st_next.prdata = {29'h0000_0000, st_reg.limit};
            end else if (paddr == `MLFP_OFF_STAT) begin
                st_next.prdata = {26'h000_0000, st_reg.status};
            end else if (paddr == `MLFP_OFF_MASK) begin
                st_next.prdata = {26'h000_0000, st_reg.mask};
            end else if (paddr == `MLFP_OFF_STATE) begin
                st_next.prdata = {24'h00_0000, st_reg.fsm, st_reg.brake,
                                  st_reg.retry_cnt, 2'b00};
            end else if (paddr == `MLFP_OFF_CTRL) begin
                st_next.prdata = 32'h0000_0000;
            end else begin
                st_next.pslverr = 1'b1;
            end
        end
        if (wr) begin
            if (paddr == `MLFP_OFF_CFG1) begin
                st_next.cfg = pwdata[10:0];
            end else if (paddr == `MLFP_OFF_LIMIT) begin
                st_next.limit = pwdata[2:0];
            end else if (paddr == `MLFP_OFF_STAT) begin
                clr = pwdata[5:0];
            end else if (paddr == `MLFP_OFF_MASK) begin
                st_next.mask = pwdata[5:0];
            end
        end
        if (st_reg.presc == UNIT_LAST) begin
            unit_tick = 1'b1;
        end
        case (st_reg.fsm)
            mlfp_pkg::MLFP_IDLE: begin
                st_next.presc = 32'h0000_0000;
                st_next.units = 8'h00;
                if (restart_ok) begin
                    st_next.retry_cnt = 3'h0;
                end
                if (lock_detect) begin
                    case (act)
                        mlfp_pkg::MLFP_ACT_LATCH_TRI: begin
                            st_next.fsm   = mlfp_pkg::MLFP_LATCH;
                            st_next.brake = 1'b0;
                            ev[`MLFP_ST_LOCK]  = 1'b1;
                            ev[`MLFP_ST_LATCH] = 1'b1;
                        end
                        mlfp_pkg::MLFP_ACT_LATCH_BRK: begin
                            st_next.fsm   = mlfp_pkg::MLFP_LATCH;
                            st_next.brake = 1'b1;
                            ev[`MLFP_ST_LOCK]  = 1'b1;
                            ev[`MLFP_ST_LATCH] = 1'b1;
                        end
                        mlfp_pkg::MLFP_ACT_RETRY_TRI,
                        mlfp_pkg::MLFP_ACT_RETRY_BRK: begin
                            // Code 7h and 6h brake; 4h and 5h tristate.
                            st_next.brake = (act == mlfp_pkg::MLFP_ACT_RETRY_BRK);
                            ev[`MLFP_ST_LOCK] = 1'b1;
                            if (st_reg.retry_cnt == st_reg.limit) begin
                                st_next.fsm = mlfp_pkg::MLFP_LATCH;
                                ev[`MLFP_ST_LATCH] = 1'b1;
                            end else begin
                                st_next.fsm = mlfp_pkg::MLFP_WAIT;
                            end
                        end
                        mlfp_pkg::MLFP_ACT_REPORT: begin
                            st_next.fsm   = mlfp_pkg::MLFP_REPORT;
                            st_next.brake = 1'b0;
                            ev[`MLFP_ST_LOCK] = 1'b1;
                        end
                        default: begin
                            st_next.fsm = mlfp_pkg::MLFP_IDLE;
                        end
                    endcase
                end
            end
            mlfp_pkg::MLFP_WAIT: begin
                st_next.presc = unit_tick ? 32'h0000_0000 : st_reg.presc + 32'h0000_0001;
                if (unit_tick) begin
                    st_next.units = st_reg.units + 8'h01;
                    // The wait ends when the selected time has elapsed.
                    if (st_reg.units + 8'h01 >= target) begin
                        st_next.fsm       = mlfp_pkg::MLFP_IDLE;
                        st_next.retry_cnt = st_reg.retry_cnt + 3'h1;
                        ev[`MLFP_ST_RETRY] = 1'b1;
                    end
                end
            end
            mlfp_pkg::MLFP_LATCH: begin
                if (wr && paddr == `MLFP_OFF_CTRL && pwdata[0]) begin
                    st_next.fsm       = mlfp_pkg::MLFP_IDLE;
                    st_next.retry_cnt = 3'h0;
                end
            end
            default: begin
                if (!lock_detect) begin
                    st_next.fsm = mlfp_pkg::MLFP_IDLE;
                end
            end
        endcase
        st_next.fault_n  = (st_next.fsm == mlfp_pkg::MLFP_IDLE);
        st_next.gate_off = ((st_next.fsm == mlfp_pkg::MLFP_WAIT) ||
                            (st_next.fsm == mlfp_pkg::MLFP_LATCH)) && !st_next.brake;
        st_next.low_on   = {3{((st_next.fsm == mlfp_pkg::MLFP_WAIT) ||
                            (st_next.fsm == mlfp_pkg::MLFP_LATCH)) && st_next.brake}};
        st_next.pto_f = probe_timeout_in && st_reg.cfg[`MLFP_PTO_BIT];
        st_next.pfq_f = probe_freq_in && st_reg.cfg[`MLFP_PFQ_BIT];
        st_next.sat_f = loop_sat_in && st_reg.cfg[`MLFP_SAT_BIT];
        ev[`MLFP_ST_PTO] = st_next.pto_f && !st_reg.pto_f;
        ev[`MLFP_ST_PFQ] = st_next.pfq_f && !st_reg.pfq_f;
        ev[`MLFP_ST_SAT] = st_next.sat_f && !st_reg.sat_f;
        // A new event wins over a clear in the same cycle.
        st_next.status = (st_reg.status & ~clr) | ev;
        st_next.irq    = |(st_next.status & st_next.mask);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg          <= '0;
            st_reg.cfg      <= `MLFP_CFG1_RESET;
            st_reg.limit    <= `MLFP_LIMIT_RESET;
            st_reg.fsm      <= mlfp_pkg::MLFP_IDLE;
            st_reg.fault_n  <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign prdata              = st_reg.prdata;
    assign pready              = st_reg.pready;
    assign pslverr             = st_reg.pslverr;
    assign fault_output_n      = st_reg.fault_n;
    assign gate_tristate       = st_reg.gate_off;
    assign low_side_on         = st_reg.low_on;
    assign probe_timeout_fault = st_reg.pto_f;
    assign probe_freq_fault    = st_reg.pfq_f;
    assign loop_sat_flag       = st_reg.sat_f;
    assign irq                 = st_reg.irq;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_wait_bound: assert property (
        (st_reg.fsm == mlfp_pkg::MLFP_WAIT) |-> (st_reg.units < target))
        else $error("Retry wait ran past its selected time.");
    a_latch_tri: assert property (
        (st_reg.fsm == mlfp_pkg::MLFP_IDLE && lock_detect &&
         act == mlfp_pkg::MLFP_ACT_LATCH_TRI) |=>
        (!fault_output_n && gate_tristate && low_side_on == 3'b000))
        else $error("Latched tristate response missing.");
    a_latch_brake: assert property (
        (st_reg.fsm == mlfp_pkg::MLFP_IDLE && lock_detect &&
         act == mlfp_pkg::MLFP_ACT_LATCH_BRK) |=>
        (!fault_output_n && !gate_tristate && low_side_on == 3'b111 &&
         st_reg.fsm == mlfp_pkg::MLFP_LATCH))
        else $error("Latched brake response missing.");
    a_retry_limit: assert property (
        (st_reg.fsm == mlfp_pkg::MLFP_IDLE && lock_detect &&
         (act == mlfp_pkg::MLFP_ACT_RETRY_TRI || act == mlfp_pkg::MLFP_ACT_RETRY_BRK) &&
         st_reg.retry_cnt == st_reg.limit) |=> (st_reg.fsm == mlfp_pkg::MLFP_LATCH))
        else $error("Fault not latched after retry limit.");
    a_retry_brake: assert property (
        (st_reg.fsm == mlfp_pkg::MLFP_IDLE && lock_detect &&
         act == mlfp_pkg::MLFP_ACT_RETRY_BRK && st_reg.retry_cnt != st_reg.limit) |=>
        (st_reg.fsm == mlfp_pkg::MLFP_WAIT && !fault_output_n && low_side_on == 3'b111))
        else $error("Retry with brake not entered.");
    a_report_only: assert property (
        (st_reg.fsm == mlfp_pkg::MLFP_IDLE && lock_detect &&
         act == mlfp_pkg::MLFP_ACT_REPORT) |=>
        (!fault_output_n && !gate_tristate && low_side_on == 3'b000))
        else $error("Report-only mode touched the drivers.");
    a_lock_off: assert property (
        (st_reg.fsm == mlfp_pkg::MLFP_IDLE && act == mlfp_pkg::MLFP_ACT_OFF) |=>
        (fault_output_n && !gate_tristate))
        else $error("Disabled lock detection raised a fault.");
    a_probe_timeout: assert property (
        1'b1 |=> (probe_timeout_fault ==
                  ($past(probe_timeout_in) && $past(st_reg.cfg[`MLFP_PTO_BIT]))))
        else $error("Probe timeout fault not gated by its enable.");
    a_probe_freq: assert property (
        1'b1 |=> (probe_freq_fault ==
                  ($past(probe_freq_in) && $past(st_reg.cfg[`MLFP_PFQ_BIT]))))
        else $error("Probe frequency fault not gated by its enable.");
    a_sat_flag: assert property (
        1'b1 |=> (loop_sat_flag ==
                  ($past(loop_sat_in) && $past(st_reg.cfg[`MLFP_SAT_BIT]))))
        else $error("Saturation flag not gated by its enable.");
    a_count_clear: assert property (
        (st_reg.fsm == mlfp_pkg::MLFP_LATCH && wr && paddr == `MLFP_OFF_CTRL &&
         pwdata[0]) |=> (st_reg.retry_cnt == 3'h0 && fault_output_n))
        else $error("Retry count not cleared with the fault.");
    a_wait_hold: assert property (
        (st_reg.fsm == mlfp_pkg::MLFP_WAIT && !unit_tick) |=>
        (st_reg.fsm == mlfp_pkg::MLFP_WAIT && !fault_output_n))
        else $error("Retry wait ended between time units.");
    a_retry_count: assert property (
        (st_reg.fsm == mlfp_pkg::MLFP_WAIT ##1 st_reg.fsm == mlfp_pkg::MLFP_IDLE) |->
        (st_reg.retry_cnt == $past(st_reg.retry_cnt) + 3'h1 && fault_output_n))
        else $error("Retry not counted at the end of the wait.");
    a_report_hold: assert property (
        (st_reg.fsm == mlfp_pkg::MLFP_REPORT && lock_detect) |=>
        (st_reg.fsm == mlfp_pkg::MLFP_REPORT && !fault_output_n &&
         !gate_tristate && low_side_on == 3'b000))
        else $error("Report-only state left while lock persists.");
    a_latch_hold: assert property (
        (st_reg.fsm == mlfp_pkg::MLFP_LATCH &&
         !(wr && paddr == `MLFP_OFF_CTRL && pwdata[0])) |=>
        (st_reg.fsm == mlfp_pkg::MLFP_LATCH && !fault_output_n))
        else $error("Latched fault released without a clear.");

    c_latch: cover property (st_reg.fsm == mlfp_pkg::MLFP_LATCH);
    c_retry_done: cover property (
        st_reg.fsm == mlfp_pkg::MLFP_WAIT ##1 st_reg.fsm == mlfp_pkg::MLFP_IDLE);
    c_report: cover property (st_reg.fsm == mlfp_pkg::MLFP_REPORT);
    c_irq: cover property (irq);
endmodule

/* sim/mlfp_top_test.sv */
// Self-checking testbench of the motor lock fault policy block.
`timescale 1ns/1ps
`include "mlfp_defs.svh"
module mlfp_top_test;
    localparam int UNIT = 4;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        lock_detect = 1'b0;
    logic        restart_ok = 1'b0;
    logic        pto_in = 1'b0;
    logic        pfq_in = 1'b0;
    logic        sat_in = 1'b0;
    logic        fault_output_n;
    logic        gate_tristate;
    logic [2:0]  low_side_on;
    logic        pto_f;
    logic        pfq_f;
    logic        sat_f;
    logic        irq;
    int          err_total = 0;
    int          check_count = 0;
    int          cycles = 0;
    logic [31:0] rd;
    logic        er;

    mlfp_top #(.UNIT_CYCLES(UNIT)) dut (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .lock_detect(lock_detect), .restart_ok(restart_ok),
        .probe_timeout_in(pto_in), .probe_freq_in(pfq_in), .loop_sat_in(sat_in),
        .fault_output_n(fault_output_n), .gate_tristate(gate_tristate),
        .low_side_on(low_side_on), .probe_timeout_fault(pto_f),
        .probe_freq_fault(pfq_f), .loop_sat_flag(sat_f), .irq(irq));

    always #2.5 pclk = ~pclk;

    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_total++;
            summarize();
        end
    end

    task automatic summarize();
        if (err_total == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One APB transfer; waits for pready, only the bench timeout ends a hang.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic setcfg(input logic [3:0] mode, input logic [3:0] wcode, input logic [2:0] en);
        apb(1'b1, `MLFP_OFF_CFG1, {21'h0, wcode, mode, en});
    endtask

    task automatic pulse_lock();
        lock_detect <= 1'b1;
        @(posedge pclk);
        lock_detect <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask

    function automatic int units(input int c);
        if (c == 0) return 3;
        if (c == 1) return 5;
        if (c == 2) return 10;
        return 20 + 10 * (c - 3);
    endfunction

    task automatic t_reset_and_enables();
        apb(1'b0, `MLFP_OFF_CFG1, 32'h0000_0000);
        check("cfg1 reset", rd, 32'h0000_0000);
        check("fault idle", 32'(fault_output_n), 32'h0000_0001);
        setcfg(4'hA, 4'hE, 3'b111);
        apb(1'b0, `MLFP_OFF_CFG1, 32'h0000_0000);
        check("cfg1 readback", rd, 32'h0000_0757);
        pto_in <= 1'b1;
        pfq_in <= 1'b1;
        sat_in <= 1'b1;
        repeat (3) @(posedge pclk);
        check("probe timeout on", 32'(pto_f), 32'h0000_0001);
        check("probe freq on", 32'(pfq_f), 32'h0000_0001);
        check("saturation on", 32'(sat_f), 32'h0000_0001);
        setcfg(4'hA, 4'h0, 3'b000);
        repeat (2) @(posedge pclk);
        check("probe timeout off", 32'(pto_f), 32'h0000_0000);
        check("probe freq off", 32'(pfq_f), 32'h0000_0000);
        check("saturation off", 32'(sat_f), 32'h0000_0000);
        pto_in <= 1'b0;
        pfq_in <= 1'b0;
        sat_in <= 1'b0;
    endtask

    task automatic t_latched();
        for (int m = 0; m < 4; m++) begin
            setcfg(4'(m), 4'h0, 3'b000);
            pulse_lock();
            check("latch fault", 32'(fault_output_n), 32'h0000_0000);
            check("latch tristate", 32'(gate_tristate), 32'(m < 2));
            check("latch brake", 32'(low_side_on), (m < 2) ? 32'h0 : 32'h7);
            repeat (40) @(posedge pclk);
            check("latch holds", 32'(fault_output_n), 32'h0000_0000);
            apb(1'b1, `MLFP_OFF_CTRL, 32'h0000_0001);
            @(posedge pclk);
            check("latch cleared", 32'(fault_output_n), 32'h0000_0001);
        end
    endtask

    task automatic t_retry();
        int n;
        int t;
        apb(1'b1, `MLFP_OFF_LIMIT, 32'h0000_0001);
        for (int m = 4; m < 8; m++) begin
            t = units(m - 4) * UNIT;
            setcfg(4'(m), 4'(m - 4), 3'b000);
            pulse_lock();
            check("retry brake", 32'(low_side_on), (m >= 6) ? 32'h7 : 32'h0);
            check("retry tristate", 32'(gate_tristate), 32'(m < 6));
            n = 0;
            while (fault_output_n === 1'b0 && n < 2000) begin
                @(posedge pclk);
                n++;
            end
            check("retry wait", 32'(n >= t - 2 && n <= t + 1), 32'h0000_0001);
            apb(1'b0, `MLFP_OFF_STATE, 32'h0000_0000);
            check("retry count", {29'h0, rd[4:2]}, 32'h0000_0001);
            pulse_lock();
            repeat (t + 8) @(posedge pclk);
            check("past limit latch", 32'(fault_output_n), 32'h0000_0000);
            apb(1'b1, `MLFP_OFF_CTRL, 32'h0000_0001);
            apb(1'b0, `MLFP_OFF_STATE, 32'h0000_0000);
            check("count after clear", {29'h0, rd[4:2]}, 32'h0000_0000);
        end
        setcfg(4'h4, 4'h0, 3'b000);
        pulse_lock();
        repeat (3 * UNIT + 4) @(posedge pclk);
        restart_ok <= 1'b1;
        @(posedge pclk);
        restart_ok <= 1'b0;
        apb(1'b0, `MLFP_OFF_STATE, 32'h0000_0000);
        check("count after restart", {29'h0, rd[4:2]}, 32'h0000_0000);
    endtask

    task automatic t_report_and_off();
        setcfg(4'h8, 4'h0, 3'b000);
        lock_detect <= 1'b1;
        repeat (3) @(posedge pclk);
        check("report fault", 32'(fault_output_n), 32'h0000_0000);
        check("report no tristate", 32'(gate_tristate), 32'h0000_0000);
        check("report no brake", 32'(low_side_on), 32'h0000_0000);
        lock_detect <= 1'b0;
        repeat (3) @(posedge pclk);
        check("report release", 32'(fault_output_n), 32'h0000_0001);
        for (int m = 9; m < 16; m++) begin
            setcfg(4'(m), 4'h0, 3'b000);
            pulse_lock();
            check("off fault", 32'(fault_output_n), 32'h0000_0001);
            check("off drivers", {28'h0, gate_tristate, low_side_on}, 32'h0000_0000);
        end
    endtask

    task automatic t_irq();
        apb(1'b1, `MLFP_OFF_STAT, 32'h0000_003F);
        apb(1'b1, `MLFP_OFF_MASK, 32'h0000_0001);
        setcfg(4'h0, 4'h0, 3'b000);
        pulse_lock();
        check("irq raised", 32'(irq), 32'h0000_0001);
        apb(1'b0, `MLFP_OFF_STAT, 32'h0000_0000);
        check("status lock latched", rd & 32'h0000_0005, 32'h0000_0005);
        apb(1'b1, `MLFP_OFF_STAT, 32'h0000_0001);
        @(posedge pclk);
        check("irq cleared", 32'(irq), 32'h0000_0000);
        apb(1'b1, `MLFP_OFF_MASK, 32'h0000_0004);
        @(posedge pclk);
        check("irq by latch bit", 32'(irq), 32'h0000_0001);
        apb(1'b1, `MLFP_OFF_MASK, 32'h0000_0000);
        @(posedge pclk);
        check("irq masked", 32'(irq), 32'h0000_0000);
        apb(1'b1, `MLFP_OFF_CTRL, 32'h0000_0001);
        apb(1'b0, 8'h40, 32'h0000_0000);
        check("unmapped error", 32'(er), 32'h0000_0001);
        check("unmapped data", rd, 32'h0000_0000);
    endtask

    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset_and_enables();
        t_latched();
        t_retry();
        t_report_and_off();
        t_irq();
        summarize();
    end
endmodule
